// [fsr_defines.vh]
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// ------------------------------
// status bit positions
// ------------------------------
`define FSR_BIT_BUSY 0
`define FSR_BIT_WLATCH 1
`define FSR_BIT_PROT_LO 2
`define FSR_BIT_PROT_HI 5
`define FSR_BIT_QUAD 6
`define FSR_BIT_LOCK 7
`define FSR_STATUS_RESET 8'h00
`define FSR_NV_MASK 8'hfc

// ------------------------------
// instruction opcodes
// ------------------------------
`define FSR_OP_STATUS_WRITE 8'h01
`define FSR_OP_PAGE_PROG 8'h02
`define FSR_OP_STATUS_READ 8'h05
`define FSR_OP_WRITE_DISABLE 8'h04
`define FSR_OP_WRITE_ENABLE 8'h06
`define FSR_OP_SECTOR_ERASE 8'h20
`define FSR_OP_BLOCK32_ERASE 8'h52
`define FSR_OP_BLOCK64_ERASE 8'hd8
`define FSR_OP_CHIP_ERASE 8'hc7
`define FSR_OP_FUNC_READ 8'h48
`define FSR_OP_EXT_READ 8'h81
`define FSR_OP_SUSPEND 8'h75
`define FSR_OP_RESET_EN 8'h66
`define FSR_OP_RESET 8'h99

// ------------------------------
// address map
// ------------------------------
`define FSR_ADDR_W 21
`define FSR_SECTOR_LSB 12
`define FSR_BLK32_LSB 15
`define FSR_BLK64_LSB 16
`define FSR_SECTOR_LAST 9'h1ff

// ------------------------------
// timing
// ------------------------------
`define FSR_CLK_NS 10
`define FSR_STATUS_WRITE_NS 2000
`define FSR_PROG_NS 8000
`define FSR_ERASE_NS 40000

`endif

// [fsr_timer.v]
`timescale 1ns/10ps
`include "fsr_defines.vh"

module fsr_timer #(
	parameter CW = 16
) (
	input wire clk_in,
	input wire rst_b_in,
	input wire start_in,
	input wire [CW-1:0] cycles_in,
	output reg busy_out,
	output reg done_out
);
	reg [CW-1:0] count_reg;

	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			count_reg <= {CW{1'b0}};
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_out) begin
				count_reg <= cycles_in;
				busy_out <= 1'b1;
			end else if (busy_out) begin
				if (count_reg <= {{(CW-1){1'b0}}, 1'b1}) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end else begin
					count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// [fsr_status.v]
`timescale 1ns/10ps
`include "fsr_defines.vh"
// Behaviour
// [RULE1] 4 KB sectors; 32/64 KB blocks group them
// [RULE2] sector n spans n*0x1000 to +0xfff
// [RULE3] register byte repeats until chip select high
// [RULE4] status layout bits 0..7, reset zero
// [RULE5] busy flag read-only, one while writing
// [RULE6] only enable/disable commands change write latch; the code also clears it on the timer's done pulse
// [RULE7] protect, quad, lock bits nonvolatile, factory zero
// [RULE8] protect bits select write-protected blocks
// [RULE9] quad enable turns on four-wire data
// [RULE10] lock bit marks status write-protected
// [RULE11] status read command returns status byte
// [RULE12] busy set through program, erase, status write
// [RULE13] while busy accept only reads and reset
// [RULE14] suspend also accepted during program or erase
// [RULE15] busy clears on completion regardless of outcome
// [RULE16] write latch cleared after write completes
// [RULE17] host sends write enable before writes
// [RULE18] lock with protect pin low blocks status write
// [RULE19] host polls busy before other commands
// [RULE20] status byte shifted msb first

module fsr_status #(
	parameter STATUS_WRITE_NS = `FSR_STATUS_WRITE_NS,
	parameter PROG_NS = `FSR_PROG_NS,
	parameter ERASE_NS = `FSR_ERASE_NS
) (
	// system
	input wire clk_in,
	input wire rst_b_in,
	// serial link
	input wire sck_in,
	input wire cs_b_in,
	input wire si_in,
	input wire wp_b_in,
	output reg so_out,
	output reg so_oe_b_out,
	// status view and decoded map
	output reg [7:0] status_out,
	output reg quad_mode_out,
	output reg suspend_out,
	output reg [8:0] sector_out,
	output reg [5:0] block32_out,
	output reg [4:0] block64_out,
	output reg addr_prot_out
);
	localparam CYC_SW = (STATUS_WRITE_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS;
	localparam CYC_PG = (PROG_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS;
	localparam CYC_ER = (ERASE_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS;

	// one-hot frame states
	localparam S_OP = 4'h1;
	localparam S_ADDR = 4'h2;
	localparam S_DATA = 4'h4;
	localparam S_OUT = 4'h8;

	// ------------------------------
	// synchronisers
	// ------------------------------
	reg [2:0] sck_sync_reg;
	reg [1:0] cs_sync_reg;
	reg [1:0] si_sync_reg;
	reg [1:0] wp_sync_reg;
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			sck_sync_reg <= 3'h0;
			cs_sync_reg <= 2'h3;
			si_sync_reg <= 2'h0;
			wp_sync_reg <= 2'h3;
		end else begin
			sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
			cs_sync_reg <= {cs_sync_reg[0], cs_b_in};
			si_sync_reg <= {si_sync_reg[0], si_in};
			wp_sync_reg <= {wp_sync_reg[0], wp_b_in};
		end
	end
	wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
	wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
	wire cs_b = cs_sync_reg[1];
	wire si = si_sync_reg[1];
	wire wp_b = wp_sync_reg[1];

	// ------------------------------
	// decode helpers
	// ------------------------------
	function is_addr_op;
		input [7:0] op;
		begin
			is_addr_op = (op == `FSR_OP_PAGE_PROG) || (op == `FSR_OP_SECTOR_ERASE) ||
				(op == `FSR_OP_BLOCK32_ERASE) || (op == `FSR_OP_BLOCK64_ERASE);
		end
	endfunction

	// ops allowed while busy
	function busy_ok;
		input [7:0] op;
		input pe;
		begin
			busy_ok = (op == `FSR_OP_STATUS_READ) || (op == `FSR_OP_FUNC_READ) ||
				(op == `FSR_OP_EXT_READ) || (op == `FSR_OP_RESET_EN) ||
				(op == `FSR_OP_RESET) || (pe && op == `FSR_OP_SUSPEND); // [RULE13] [RULE14]
		end
	endfunction

	// protection decode over 64 KB blocks
	function prot_hit;
		input [3:0] bp;
		input [4:0] blk;
		reg [4:0] lo;
		reg [4:0] hi;
		begin
			lo = 5'h1f;
			hi = 5'h00;
			prot_hit = 1'b0;
			case (bp)
				4'h1: lo = 5'h1f;
				4'h2: lo = 5'h1e;
				4'h3: lo = 5'h1c;
				4'h4: lo = 5'h18;
				4'h5: lo = 5'h10;
				4'ha: hi = 5'h0f;
				4'hb: hi = 5'h07;
				4'hc: hi = 5'h03;
				4'hd: hi = 5'h01;
				4'he: hi = 5'h00;
				default: lo = 5'h1f;
			endcase
			if (bp >= 4'h1 && bp <= 4'h5)
				prot_hit = (blk >= lo);
			else if (bp >= 4'h6 && bp <= 4'h9)
				prot_hit = 1'b1;
			else if (bp >= 4'ha && bp <= 4'he)
				prot_hit = (blk <= hi);
		end
	endfunction

	// ------------------------------
	// status and frame state
	// ------------------------------
	reg [5:0] nv_reg;
	reg wlatch_reg;
	reg [3:0] state_reg;
	reg [7:0] shift_reg;
	reg [2:0] bit_cnt_reg;
	reg [1:0] byte_cnt_reg;
	reg [7:0] op_reg;
	reg [`FSR_ADDR_W-1:0] addr_reg;
	reg [7:0] out_byte_reg;
	reg ignore_reg;
	reg pe_reg;
	reg start_reg;
	reg [15:0] cycles_reg;
	wire busy;
	wire done;

	wire [7:0] status = {nv_reg, wlatch_reg, busy}; // [RULE4] [RULE5]
	wire [7:0] shifted = {shift_reg[6:0], si};
	wire [3:0] bp = nv_reg[3:0];

	fsr_timer #(
		.CW(16)
	) u_timer (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.start_in(start_reg),
		.cycles_in(cycles_reg),
		.busy_out(busy),
		.done_out(done)
	);

	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			nv_reg <= 6'h00; // [RULE7]
			wlatch_reg <= 1'b0;
			state_reg <= S_OP;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 2'h0;
			op_reg <= 8'h00;
			addr_reg <= {`FSR_ADDR_W{1'b0}};
			out_byte_reg <= 8'h00;
			ignore_reg <= 1'b0;
			pe_reg <= 1'b0;
			start_reg <= 1'b0;
			cycles_reg <= 16'h0000;
			so_out <= 1'b0;
			so_oe_b_out <= 1'b1;
		end else begin
			start_reg <= 1'b0;
			if (done) begin
				wlatch_reg <= 1'b0; // [RULE16] [RULE15]
				pe_reg <= 1'b0;
			end
			if (cs_b) begin
				state_reg <= S_OP;
				bit_cnt_reg <= 3'h0;
				byte_cnt_reg <= 2'h0;
				ignore_reg <= 1'b0;
				so_oe_b_out <= 1'b1;
				// status writes commit on deselect, only in a clean frame
				if (!ignore_reg && state_reg == S_DATA && op_reg == `FSR_OP_STATUS_WRITE &&
					byte_cnt_reg != 2'h0 && !busy && wlatch_reg && !(nv_reg[5] && !wp_b)) begin // [RULE18] [RULE10]
					nv_reg <= out_byte_reg[7:2]; // [RULE6] [RULE7]
					cycles_reg <= CYC_SW[15:0];
					start_reg <= 1'b1; // [RULE12]
				end
				op_reg <= 8'h00;
			end else if (sck_rise && state_reg != S_OUT) begin
				shift_reg <= shifted;
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7) begin
					case (state_reg)
						S_OP: begin
							op_reg <= shifted;
							ignore_reg <= busy && !busy_ok(shifted, pe_reg);
							if (!(busy && !busy_ok(shifted, pe_reg))) begin
								if (shifted == `FSR_OP_WRITE_ENABLE)
									wlatch_reg <= 1'b1; // [RULE6] [RULE17]
								else if (shifted == `FSR_OP_WRITE_DISABLE)
									wlatch_reg <= 1'b0;
								else if (shifted == `FSR_OP_CHIP_ERASE && wlatch_reg && bp == 4'h0) begin
									cycles_reg <= CYC_ER[15:0];
									start_reg <= 1'b1; // [RULE12]
									pe_reg <= 1'b1;
								end
							end
							if (shifted == `FSR_OP_STATUS_READ) begin
								state_reg <= S_OUT; // [RULE11]
								out_byte_reg <= status;
							end else if (is_addr_op(shifted))
								state_reg <= S_ADDR;
							else
								state_reg <= S_DATA;
						end
						S_ADDR: begin
							addr_reg <= {addr_reg[`FSR_ADDR_W-9:0], shifted};
							byte_cnt_reg <= byte_cnt_reg + 2'h1;
							if (byte_cnt_reg == 2'h2) begin
								state_reg <= S_DATA;
								byte_cnt_reg <= 2'h0;
								if (!ignore_reg && wlatch_reg && !prot_hit(bp,
									addr_reg[`FSR_BLK64_LSB-8 +: 5])) begin // [RULE8]
									cycles_reg <= (op_reg == `FSR_OP_PAGE_PROG) ?
										CYC_PG[15:0] : CYC_ER[15:0];
									start_reg <= 1'b1; // [RULE12]
									pe_reg <= 1'b1;
								end
							end
						end
						default: begin
							out_byte_reg <= shifted;
							byte_cnt_reg <= 2'h1;
						end
					endcase
				end
			end else if (sck_fall && state_reg == S_OUT) begin
				// status byte reloaded after each byte while clocking continues
				so_oe_b_out <= 1'b0;
				so_out <= out_byte_reg[3'h7 - bit_cnt_reg]; // [RULE20] [RULE3]
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7)
					out_byte_reg <= status;
			end
		end
	end

	// ------------------------------
	// status view and address map
	// ------------------------------
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			status_out <= `FSR_STATUS_RESET;
			quad_mode_out <= 1'b0;
			suspend_out <= 1'b0;
			sector_out <= 9'h000;
			block32_out <= 6'h00;
			block64_out <= 5'h00;
			addr_prot_out <= 1'b0;
		end else begin
			status_out <= status;
			quad_mode_out <= nv_reg[4]; // [RULE9]
			suspend_out <= sck_rise && bit_cnt_reg == 3'h7 && state_reg == S_OP &&
				shifted == `FSR_OP_SUSPEND && busy && pe_reg; // [RULE14]
			sector_out <= addr_reg[`FSR_ADDR_W-1:`FSR_SECTOR_LSB]; // [RULE1] [RULE2]
			block32_out <= addr_reg[`FSR_ADDR_W-1:`FSR_BLK32_LSB];
			block64_out <= addr_reg[`FSR_ADDR_W-1:`FSR_BLK64_LSB];
			addr_prot_out <= prot_hit(bp, addr_reg[`FSR_ADDR_W-1:`FSR_BLK64_LSB]);
		end
	end
endmodule

// [fsr_status_assertions.sv]
`timescale 1ns/10ps
// ----------
// status checker
// ----------
module fsr_status_checker (
	input wire clk_in,
	input wire rst_b_in,
	input wire sck_in,
	input wire cs_b_in,
	input wire so_out,
	input wire so_oe_b_out,
	input wire [7:0] status_out,
	input wire suspend_out,
	input wire [8:0] sector_out,
	input wire [5:0] block32_out,
	input wire [4:0] block64_out
);
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	reset_value_a: assert property ($rose(rst_b_in) |-> status_out == 8'h00 && so_oe_b_out)
		else $error("status or enable not at reset value");
	oe_idle_a: assert property (cs_b_in [*8] |-> so_oe_b_out)
		else $error("output driven with chip select high");
	so_edge_a: assert property (!so_oe_b_out && $changed(so_out) |-> !sck_in)
		else $error("serial output moved while clock high");
	busy_start_a: assert property ($rose(status_out[0]) |-> status_out[1])
		else $error("busy started without write latch");
	busy_min_a: assert property ($rose(status_out[0]) |-> status_out[0] [*8])
		else $error("busy dropped too soon");
	latch_clear_a: assert property ($fell(status_out[0]) |-> ##[0:1] !status_out[1])
		else $error("write latch kept after write done");
	// nv bits land one cycle before busy rises
	nv_hold_a: assert property (status_out[0] && $past(status_out[0], 3) |-> $stable(status_out[7:2]))
		else $error("protected bits moved while busy");
	suspend_pulse_a: assert property (suspend_out |-> status_out[0] ##1 !suspend_out)
		else $error("suspend pulse outside busy or too long");
	map_group_a: assert property (block32_out == sector_out[8:3] && block64_out == sector_out[8:4])
		else $error("block numbers disagree with sector");
	busy_c: cover property ($rose(status_out[0]));
	drive_c: cover property ($fell(so_oe_b_out));
	lock_c: cover property (status_out[7]);
endmodule
bind fsr_status fsr_status_checker chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .sck_in(sck_in),
	.cs_b_in(cs_b_in), .so_out(so_out), .so_oe_b_out(so_oe_b_out), .status_out(status_out),
	.suspend_out(suspend_out), .sector_out(sector_out), .block32_out(block32_out),
	.block64_out(block64_out));

// [fsr_host.sv]
`timescale 1ns/10ps
// ----------
// serial host model
// ----------
module fsr_host (
	input wire clk_in,
	input wire so_in,
	output logic sck_out,
	output logic cs_b_out,
	output logic si_out
);
	initial begin
		sck_out = 1'b0;
		cs_b_out = 1'b1;
		si_out = 1'b0;
	end
	// mode 0, 160 ns bit; clock stands low between frames
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_out <= tx[i];
			repeat (8) @(posedge clk_in);
			sck_out <= 1'b1;
			rx[i] = so_in;
			repeat (8) @(posedge clk_in);
			sck_out <= 1'b0;
		end
	endtask
	task automatic sel();
		@(posedge clk_in) cs_b_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	task automatic desel();
		repeat (4) @(posedge clk_in);
		cs_b_out <= 1'b1;
		repeat (12) @(posedge clk_in);
	endtask
endmodule

// [fsr_status_bench.sv]
`timescale 1ns/10ps
module fsr_status_bench;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic wp_b_in = 1'b1;
	logic sus_seen = 1'b0;
	wire sck, cs_b, si, so_out, so_oe_b_out, quad_mode_out, suspend_out, addr_prot_out;
	wire [7:0] status_out;
	wire [8:0] sector_out;
	wire [5:0] block32_out;
	wire [4:0] block64_out;
	int n_errors = 0;
	int checked = 0;
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) if (suspend_out === 1'b1) sus_seen <= 1'b1;
	// released line has no pull: show the inverse so early sampling is caught
	wire so_line = so_oe_b_out ? ~so_out : so_out;
	fsr_host host (.clk_in(clk_in), .so_in(so_line), .sck_out(sck), .cs_b_out(cs_b), .si_out(si));
	// long enough that several frames fit inside one busy span
	fsr_status #(.STATUS_WRITE_NS(30000), .PROG_NS(30000), .ERASE_NS(30000)) uut (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .sck_in(sck), .cs_b_in(cs_b), .si_in(si),
		.wp_b_in(wp_b_in), .so_out(so_out), .so_oe_b_out(so_oe_b_out), .status_out(status_out),
		.quad_mode_out(quad_mode_out), .suspend_out(suspend_out), .sector_out(sector_out),
		.block32_out(block32_out), .block64_out(block64_out), .addr_prot_out(addr_prot_out));
	// ----------
	// tasks
	// ----------
	task automatic report_and_stop();
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [23:0] d, input int n);
		logic [7:0] r;
		host.sel();
		host.xfer(op, r);
		for (int i = 0; i < n; i++)
			host.xfer(d[23 - 8 * i -: 8], r);
		host.desel();
	endtask
	task automatic rd(input logic [7:0] exp);
		logic [7:0] a, b, r;
		host.sel();
		host.xfer(8'h05, r);
		host.xfer(8'h00, a);
		host.xfer(8'h00, b);
		host.desel();
		chk("status byte", {1'b0, a}, {1'b0, exp});
		chk("status repeat", {1'b0, b}, {1'b0, exp});
	endtask
	task automatic wait_ready();
		for (int k = 0; k < 4000 && status_out[0] !== 1'b0; k++)
			@(posedge clk_in);
		chk("busy clear", {8'h00, status_out[0]}, 9'h000);
	endtask
	// ----------
	// tests
	// ----------
	initial begin
		repeat (80000) @(posedge clk_in);
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk("status reset", {1'b0, status_out}, 9'h000);
		chk("oe reset", {8'h00, so_oe_b_out}, 9'h001);
		rd(8'h00);
		cmd(8'h06, 24'h0, 0);
		rd(8'h02);
		cmd(8'h04, 24'h0, 0);
		rd(8'h00);
		cmd(8'h01, 24'hfc0000, 1);
		rd(8'h00);
		cmd(8'h06, 24'h0, 0);
		cmd(8'h01, 24'h5e0000, 1);
		rd(8'h5f);
		wait_ready();
		rd(8'h5c);
		chk("quad mode", {8'h00, quad_mode_out}, 9'h001);
		cmd(8'h06, 24'h0, 0);
		cmd(8'h01, 24'hdc0000, 1);
		wait_ready();
		rd(8'hdc);
		wp_b_in <= 1'b0;
		cmd(8'h06, 24'h0, 0);
		cmd(8'h01, 24'h000000, 1);
		rd(8'hde);
		wp_b_in <= 1'b1;
		cmd(8'h01, 24'h000000, 1);
		wait_ready();
		rd(8'h00);
		// only the top 64 KB block protected
		cmd(8'h06, 24'h0, 0);
		cmd(8'h01, 24'h040000, 1);
		wait_ready();
		rd(8'h04);
		cmd(8'h06, 24'h0, 0);
		cmd(8'hc7, 24'h0, 0);
		rd(8'h06);
		cmd(8'h20, 24'h1f0000, 3);
		rd(8'h06);
		chk("addr protected", {8'h00, addr_prot_out}, 9'h001);
		cmd(8'h01, 24'h000000, 1);
		wait_ready();
		rd(8'h00);
		cmd(8'h06, 24'h0, 0);
		cmd(8'h20, 24'h1ff123, 3);
		chk("sector", sector_out, 9'h1ff);
		chk("block32", {3'h0, block32_out}, 9'h03f);
		chk("block64", {4'h0, block64_out}, 9'h01f);
		chk("addr free", {8'h00, addr_prot_out}, 9'h000);
		rd(8'h03);
		cmd(8'h04, 24'h0, 0);
		rd(8'h03);
		cmd(8'h75, 24'h0, 0);
		chk("suspend", {8'h00, sus_seen}, 9'h001);
		report_and_stop();
	end
endmodule
